// ---- hibernate_ctrl_irq.sv ----
/*
 * Hibernation unit control: enable, pin retention, four masked events,
 * a sixteen word backed store and an AXI4-Lite register slave.
 * Assumes RST_I is the always-powered reset, CPU_RST_I the processor's
 * power-on reset, and all inputs synchronous to MCLK_I.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hib_cfg.svh"

module hibernate_ctrl_irq (
    // Clock and resets
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CPU_RST_I,
    // AXI4-Lite write address and data
    input wire logic [`HIB_ADDR_W-1:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [`HIB_DATA_W-1:0] WDATA_I,
    input wire logic [`HIB_STRB_W-1:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    // AXI4-Lite write response
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    // AXI4-Lite read
    input wire logic [`HIB_ADDR_W-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [`HIB_DATA_W-1:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // Event sources and hibernation state
    input wire logic HIB_I,
    input wire logic WAKE_PIN_I,
    input wire logic RTC_MATCH0_I,
    input wire logic BAT_LOW_I,
    // Pin logic side and pins
    input wire logic [`HIB_PIN_W-1:0] GPIO_OUT_I,
    input wire logic [`HIB_PIN_W-1:0] GPIO_OE_I,
    output logic GPIO_RST_O,
    output logic [`HIB_PIN_W-1:0] PIN_OUT_O,
    output logic [`HIB_PIN_W-1:0] PIN_OE_O,
    // Interrupt request
    output logic IRQ_O
);

    hib_pkg::hib_s st_reg;
    hib_pkg::hib_s st_next;

    logic chk_busy;
    logic chk_done;
    logic chk_low;

    // ------------------------------------------------------------------
    // Battery checker
    // ------------------------------------------------------------------

    // The checker sits beside the event logic; its start is a pulse.
    hib_bat_check u_bat_check (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .start_i(st_reg.chk_start),
        .bat_low_i(BAT_LOW_I),
        .busy_o(chk_busy),
        .done_o(chk_done),
        .low_o(chk_low)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Merge a write into an old word, byte lane by byte lane.
    function automatic logic [`HIB_DATA_W-1:0] merge(
        input logic [`HIB_DATA_W-1:0] old_w,
        input logic [`HIB_DATA_W-1:0] new_w,
        input logic [`HIB_STRB_W-1:0] strb
    );
        logic [`HIB_DATA_W-1:0] res;
        res = old_w;
        for (int b = 0; b < `HIB_STRB_W; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // True when an address falls in the backed store window.
    function automatic logic in_mem(input logic [`HIB_ADDR_W-1:0] a);
        return (a[`HIB_ADDR_W-1:6] == 2'(`HIB_OFS_MEM_BASE >> 6));
    endfunction : in_mem

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // All behaviour in one pass: bus slave, events, retention, pins.
    always_comb begin
        logic [`HIB_EVT_W-1:0] set_evt;
        logic [`HIB_EVT_W-1:0] clr_evt;
        logic [`HIB_EVT_W-1:0] masked;
        logic [`HIB_DATA_W-1:0] ctrl_word;
        logic [`HIB_DATA_W-1:0] wd;
        logic [`HIB_MEM_IDX_W-1:0] widx;
        logic [`HIB_MEM_IDX_W-1:0] ridx;
        logic hib_rise;
        set_evt = '0;
        clr_evt = '0;
        masked = '0;
        ctrl_word = '0;
        wd = '0;
        widx = '0;
        ridx = ARADDR_I[5:2];
        hib_rise = HIB_I & ~st_reg.hib_prev;
        st_next = st_reg;
        st_next.chk_start = 1'b0;

        // Write address and data are taken in either order.
        if (AWVALID_I && st_reg.awready) begin
            st_next.aw_got = 1'b1;
            st_next.waddr = AWADDR_I;
        end
        if (WVALID_I && st_reg.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = WDATA_I;
            st_next.wstrb = WSTRB_I;
        end

        // Perform the write once both halves are held.
        unique case (st_reg.wr_state)
            hib_pkg::WR_IDLE: begin
                if (st_next.aw_got && st_next.w_got) begin
                    st_next.aw_got = 1'b0;
                    st_next.w_got = 1'b0;
                    st_next.bvalid = 1'b1;
                    st_next.bresp = `HIB_RESP_OKAY;
                    st_next.wr_state = hib_pkg::WR_RESP;
                    wd = merge('0, st_next.wdata, st_next.wstrb);
                    widx = st_next.waddr[5:2];
                    if (in_mem(st_next.waddr)) begin
                        st_next.mem[widx] = merge(st_reg.mem[widx],
                            st_next.wdata, st_next.wstrb);
                        set_evt[`HIB_EVT_WR_DONE] = 1'b1;
                    end else begin
                        unique case (st_next.waddr)
                            `HIB_OFS_CTRL: begin
                                if (st_next.wstrb[0]) begin
                                    st_next.enable =
                                        wd[`HIB_CTRL_ENABLE];
                                    st_next.retain =
                                        wd[`HIB_CTRL_RETAIN];
                                    st_next.chk_start =
                                        wd[`HIB_CTRL_CHK_START] &
                                        st_reg.enable;
                                end
                            end
                            `HIB_OFS_MASK: begin
                                if (st_next.wstrb[0]) begin
                                    st_next.mask =
                                        wd[`HIB_EVT_W-1:0];
                                end
                            end
                            `HIB_OFS_RAW, `HIB_OFS_CLEAR: begin
                                clr_evt = wd[`HIB_EVT_W-1:0];
                            end
                            `HIB_OFS_VIEW: begin
                                if (st_next.wstrb[0]) begin
                                    st_next.view_masked = wd[0];
                                end
                            end
                            `HIB_OFS_MSK_STAT: begin
                                // Read-only view; the write is ignored.
                            end
                            default: begin
                                st_next.bresp = `HIB_RESP_SLVERR;
                            end
                        endcase
                    end
                end
            end
            hib_pkg::WR_RESP: begin
                if (BREADY_I) begin
                    st_next.bvalid = 1'b0;
                    st_next.wr_state = hib_pkg::WR_IDLE;
                end
            end
        endcase
        st_next.awready = ~st_next.aw_got & ~st_next.bvalid;
        st_next.wready = ~st_next.w_got & ~st_next.bvalid;

        // Event capture; a disabled unit raises nothing.
        st_next.wake_prev = WAKE_PIN_I;
        if (st_reg.enable) begin
            if (WAKE_PIN_I && !st_reg.wake_prev) begin
                set_evt[`HIB_EVT_PIN_WAKE] = 1'b1;
            end
            if (RTC_MATCH0_I) begin
                set_evt[`HIB_EVT_RTC_MATCH0] = 1'b1;
            end
            if (chk_done && chk_low) begin
                set_evt[`HIB_EVT_LOW_BAT] = 1'b1;
            end
        end else begin
            set_evt = '0;
        end

        // A set arriving with its clear wins, so no event is lost.
        st_next.raw = (st_reg.raw & ~clr_evt) | set_evt;
        masked = st_next.raw & st_next.mask;
        st_next.irq = st_next.enable & (|masked);

        // Read channel answers one cycle after the address is taken.
        ctrl_word[`HIB_CTRL_ENABLE] = st_reg.enable;
        ctrl_word[`HIB_CTRL_RETAIN] = st_reg.retain;
        ctrl_word[`HIB_CTRL_ACTIVE] = st_reg.enable;
        ctrl_word[`HIB_CTRL_CHK_BUSY] = chk_busy | st_reg.chk_start;
        ctrl_word[`HIB_CTRL_HOLDING] = st_reg.holding;
        unique case (st_reg.rd_state)
            hib_pkg::RD_IDLE: begin
                if (ARVALID_I) begin
                    st_next.arready = 1'b0;
                    st_next.rvalid = 1'b1;
                    st_next.rresp = `HIB_RESP_OKAY;
                    st_next.rdata = '0;
                    st_next.rd_state = hib_pkg::RD_DATA;
                    if (in_mem(ARADDR_I)) begin
                        st_next.rdata = st_reg.mem[ridx];
                    end else begin
                        unique case (ARADDR_I)
                            `HIB_OFS_CTRL: st_next.rdata = ctrl_word;
                            `HIB_OFS_MASK: begin
                                st_next.rdata[`HIB_EVT_W-1:0] = st_reg.mask;
                            end
                            `HIB_OFS_RAW: begin
                                st_next.rdata[`HIB_EVT_W-1:0] =
                                    st_reg.view_masked ?
                                    (st_reg.raw & st_reg.mask) :
                                    st_reg.raw;
                            end
                            `HIB_OFS_MSK_STAT: begin
                                st_next.rdata[`HIB_EVT_W-1:0] =
                                    st_reg.raw & st_reg.mask;
                            end
                            `HIB_OFS_CLEAR: st_next.rdata = '0;
                            `HIB_OFS_VIEW: begin
                                st_next.rdata[0] = st_reg.view_masked;
                            end
                            default: st_next.rresp = `HIB_RESP_SLVERR;
                        endcase
                    end
                end
            end
            hib_pkg::RD_DATA: begin
                if (RREADY_I) begin
                    st_next.rvalid = 1'b0;
                    st_next.arready = 1'b1;
                    st_next.rd_state = hib_pkg::RD_IDLE;
                end
            end
        endcase

        // Retention: capture the pin levels as hibernation begins.
        st_next.hib_prev = HIB_I;
        if (!st_reg.enable) begin
            st_next.holding = 1'b0;
        end else if (hib_rise && st_reg.retain && !st_reg.holding) begin
            st_next.holding = 1'b1;
            st_next.kept_out = GPIO_OUT_I;
            st_next.kept_oe = GPIO_OE_I;
        end else if (!st_reg.retain && !HIB_I) begin
            st_next.holding = 1'b0;
        end

        // Pins follow retained levels, the pin logic, or nothing.
        st_next.gpio_rst = HIB_I;
        if (st_next.holding) begin
            st_next.pin_out = st_next.kept_out;
            st_next.pin_oe = st_next.kept_oe;
        end else if (HIB_I) begin
            st_next.pin_out = '0;
            st_next.pin_oe = '0;
        end else begin
            st_next.pin_out = GPIO_OUT_I;
            st_next.pin_oe = GPIO_OE_I;
        end

        // The processor reset clears only the bus side of the slave and the check start pulse.
        if (CPU_RST_I) begin
            st_next.wr_state = hib_pkg::WR_IDLE;
            st_next.rd_state = hib_pkg::RD_IDLE;
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
            st_next.bvalid = 1'b0;
            st_next.arready = 1'b1;
            st_next.rvalid = 1'b0;
            st_next.chk_start = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Only the unit reset clears all state; processor resets keep all but the bus side and the check start pulse.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            st_reg <= '{
                wr_state: hib_pkg::WR_IDLE,
                rd_state: hib_pkg::RD_IDLE,
                awready: 1'b1,
                wready: 1'b1,
                arready: 1'b1,
                mask: `HIB_MASK_RST,
                default: '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign AWREADY_O = st_reg.awready;
    assign WREADY_O = st_reg.wready;
    assign BVALID_O = st_reg.bvalid;
    assign BRESP_O = st_reg.bresp;
    assign ARREADY_O = st_reg.arready;
    assign RVALID_O = st_reg.rvalid;
    assign RRESP_O = st_reg.rresp;
    assign RDATA_O = st_reg.rdata;
    assign GPIO_RST_O = st_reg.gpio_rst;
    assign PIN_OUT_O = st_reg.pin_out;
    assign PIN_OE_O = st_reg.pin_oe;
    assign IRQ_O = st_reg.irq;

endmodule : hibernate_ctrl_irq
`default_nettype wire

// ---- hib_cfg.svh ----
/*
 * Offsets, fields, reset values, sizes and timing counts of the block.
 * Assumes inclusion by bare name wherever a figure is needed.
 */
`ifndef HIB_CFG_SVH
`define HIB_CFG_SVH

// ----------------------------------------------------------------------
// Bus and sizes
// ----------------------------------------------------------------------
`define HIB_ADDR_W 8
`define HIB_DATA_W 32
`define HIB_STRB_W 4
`define HIB_PIN_W 8
`define HIB_EVT_W 4
`define HIB_MEM_WORDS 16
`define HIB_MEM_IDX_W 4

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define HIB_OFS_CTRL 8'h00
`define HIB_OFS_MASK 8'h04
`define HIB_OFS_RAW 8'h08
`define HIB_OFS_MSK_STAT 8'h0c
`define HIB_OFS_CLEAR 8'h10
`define HIB_OFS_VIEW 8'h14
`define HIB_OFS_MEM_BASE 8'h40

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define HIB_CTRL_ENABLE 0
`define HIB_CTRL_RETAIN 1
`define HIB_CTRL_ACTIVE 2
`define HIB_CTRL_CHK_START 3
`define HIB_CTRL_CHK_BUSY 4
`define HIB_CTRL_HOLDING 5

// ----------------------------------------------------------------------
// Event bit layout, shared by mask, raw, masked and clear
// ----------------------------------------------------------------------
`define HIB_EVT_RTC_MATCH0 0
`define HIB_EVT_LOW_BAT 1
`define HIB_EVT_PIN_WAKE 2
`define HIB_EVT_WR_DONE 3

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define HIB_MASK_RST 4'h0
`define HIB_RESP_OKAY 2'h0
`define HIB_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HIB_CLK_PERIOD_NS 8
`define HIB_BAT_CHECK_NS 1000
`define HIB_BAT_CHECK_CYC \
    ((`HIB_BAT_CHECK_NS + `HIB_CLK_PERIOD_NS - 1) / `HIB_CLK_PERIOD_NS)
`define HIB_CHK_CNT_W 8

`endif

// ---- hib_pkg.sv ----
/*
 * State enumerations and packed state records of both modules.
 * Assumes hib_cfg.svh is on the include path.
 */
`default_nettype none
`include "hib_cfg.svh"

package hib_pkg;

    // ------------------------------------------------------------------
    // State enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_e;

    typedef enum logic [1:0] {
        CHK_IDLE = 2'b01,
        CHK_RUN = 2'b10
    } chk_state_e;

    // ------------------------------------------------------------------
    // Battery checker state
    // ------------------------------------------------------------------
    typedef struct packed {
        chk_state_e state;
        logic [`HIB_CHK_CNT_W-1:0] count;
        logic busy;
        logic done;
        logic low;
    } chk_s;

    typedef logic [`HIB_MEM_WORDS-1:0][`HIB_DATA_W-1:0] mem_t;

    // ------------------------------------------------------------------
    // Main block state
    // ------------------------------------------------------------------
    typedef struct packed {
        wr_state_e wr_state;
        rd_state_e rd_state;
        logic aw_got;
        logic w_got;
        logic [`HIB_ADDR_W-1:0] waddr;
        logic [`HIB_DATA_W-1:0] wdata;
        logic [`HIB_STRB_W-1:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [`HIB_DATA_W-1:0] rdata;
        logic enable;
        logic retain;
        logic view_masked;
        logic [`HIB_EVT_W-1:0] mask;
        logic [`HIB_EVT_W-1:0] raw;
        logic chk_start;
        logic hib_prev;
        logic wake_prev;
        logic holding;
        logic [`HIB_PIN_W-1:0] kept_out;
        logic [`HIB_PIN_W-1:0] kept_oe;
        logic [`HIB_PIN_W-1:0] pin_out;
        logic [`HIB_PIN_W-1:0] pin_oe;
        logic gpio_rst;
        logic irq;
        mem_t mem;
    } hib_s;

endpackage : hib_pkg
`default_nettype wire

// ---- hib_bat_check.sv ----
/*
 * Forced battery check: on start, wait the settle time, sample the
 * low-battery comparator and pulse done with the result.
 * Assumes the comparator level is synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hib_cfg.svh"

module hib_bat_check (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request and comparator
    input wire logic start_i,
    input wire logic bat_low_i,
    // Result
    output logic busy_o,
    output logic done_o,
    output logic low_o
);

    localparam logic [`HIB_CHK_CNT_W-1:0] CHK_LAST =
        `HIB_CHK_CNT_W'(`HIB_BAT_CHECK_CYC - 1);

    hib_pkg::chk_s chk_reg;
    hib_pkg::chk_s chk_next;

    // Count the settle time, then take one comparator sample.
    always_comb begin
        chk_next = chk_reg;
        chk_next.done = 1'b0;
        unique case (chk_reg.state)
            hib_pkg::CHK_IDLE: begin
                if (start_i) begin
                    chk_next.state = hib_pkg::CHK_RUN;
                    chk_next.count = '0;
                    chk_next.busy = 1'b1;
                end
            end
            hib_pkg::CHK_RUN: begin
                if (chk_reg.count == CHK_LAST) begin
                    chk_next.state = hib_pkg::CHK_IDLE;
                    chk_next.busy = 1'b0;
                    chk_next.done = 1'b1;
                    chk_next.low = bat_low_i;
                end else begin
                    chk_next.count = chk_reg.count + 1'b1;
                end
            end
        endcase
    end

    // Register the state; reset returns to idle with no result.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_reg <= '{state: hib_pkg::CHK_IDLE, default: '0};
        end else begin
            chk_reg <= chk_next;
        end
    end

    assign busy_o = chk_reg.busy;
    assign done_o = chk_reg.done;
    assign low_o = chk_reg.low;

endmodule : hib_bat_check
`default_nettype wire

// ---- hib_chk.sv ----
/* Checker of bus handshakes and pin-logic reset of the hibernation block.
   Assumes it is bound onto hibernate_ctrl_irq and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "hib_cfg.svh"
module hib_chk (
    // Clock and resets
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CPU_RST_I,
    // Register bus
    input wire logic AWVALID_I,
    input wire logic AWREADY_O,
    input wire logic WVALID_I,
    input wire logic WREADY_O,
    input wire logic [1:0] BRESP_O,
    input wire logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic [`HIB_DATA_W-1:0] RDATA_O,
    input wire logic RVALID_O,
    input wire logic RREADY_I,
    // Pins
    input wire logic HIB_I,
    input wire logic GPIO_RST_O
);
    // A processor reset drops handshakes, so it pauses the checks too.
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I || CPU_RST_I);
    // Both write items taken at one edge, and a pending answer.
    sequence s_w_taken;
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
    endsequence
    sequence s_b_wait;
        BVALID_O && !BREADY_I;
    endsequence
    a_b_answer: assert property (s_w_taken |=> BVALID_O)
        else $error("write answer late");
    a_b_stands: assert property (s_b_wait |=> BVALID_O && $stable(BRESP_O))
        else $error("write answer dropped");
    a_w_refused: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("write taken while answering");
    a_w_back: assert property (BVALID_O && BREADY_I |=> AWREADY_O && WREADY_O)
        else $error("write ready not back");
    a_r_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
        else $error("read answer late");
    a_r_stands: assert property (RVALID_O && !RREADY_I |=> $stable(RDATA_O))
        else $error("read data moved");
    a_r_refused: assert property (RVALID_O |-> !ARREADY_O)
        else $error("read taken while answering");
    a_gpio_reset: assert property ($rose(HIB_I) |=> GPIO_RST_O)
        else $error("pin logic not reset");
    a_gpio_free: assert property ($fell(HIB_I) |=> !GPIO_RST_O)
        else $error("pin logic held in reset");
endmodule : hib_chk
bind hibernate_ctrl_irq hib_chk u_chk (.*);
`default_nettype wire

// ---- tb_hibernate_ctrl_irq.sv ----
/* Self-checking bench of the hibernation block: bus, events, store, pins.
   Assumes the design and its checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "hib_cfg.svh"
module tb_hibernate_ctrl_irq;
    // Stimulus valued at time zero; observed signals are driven by the design.
    logic clk = 1'b0, rst = 1'b1, cpu_rst = 1'b0, hib = 1'b0, wake = 1'b0;
    logic rtc = 1'b0, bat = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, gout = 8'h00, goe = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, grst, irq;
    logic [1:0] bresp, rresp;
    logic [7:0] pout, poe;
    int fail_count = 0, check_count = 0;
    hibernate_ctrl_irq u_dut (.MCLK_I(clk), .RST_I(rst), .CPU_RST_I(cpu_rst),
        .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(rready), .HIB_I(hib),
        .WAKE_PIN_I(wake), .RTC_MATCH0_I(rtc), .BAT_LOW_I(bat),
        .GPIO_OUT_I(gout), .GPIO_OE_I(goe), .GPIO_RST_O(grst),
        .PIN_OUT_O(pout), .PIN_OE_O(poe), .IRQ_O(irq));
    always #4 clk = ~clk;
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Bus tasks start one edge late, so no strobe is set twice at once.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = `HIB_RESP_OKAY);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 50 && bvalid !== 1'b1; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (n == 50) begin
            fail_count++;
            give_verdict();
        end
        check(bresp, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r = `HIB_RESP_OKAY);
        int n;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 50 && rvalid !== 1'b1; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (n == 50) begin
            fail_count++;
            give_verdict();
        end
        check(rdata, e);
        check(rresp, r);
    endtask : rd
    // One-cycle match pulse; its raw bit lands one edge later.
    task automatic pulse_rtc();
        rtc <= 1'b1;
        tick(1);
        rtc <= 1'b0;
        tick(2);
    endtask : pulse_rtc
    task automatic t_events();
        rd(`HIB_OFS_CTRL, 32'h0);
        wr(8'h20, 32'h1, `HIB_RESP_SLVERR);
        rd(8'h20, 32'h0, `HIB_RESP_SLVERR);
        wr(`HIB_OFS_CTRL, 32'h1);
        wr(`HIB_OFS_MASK, 32'h1);
        pulse_rtc();
        check(irq, 32'h1);
        wake <= 1'b1;
        tick(2);
        wake <= 1'b0;
        rd(`HIB_OFS_MSK_STAT, 32'h1);
        rd(`HIB_OFS_RAW, 32'h5);
        wr(`HIB_OFS_CLEAR, 32'h1);
        tick(2);
        check(irq, 32'h0);
        rd(`HIB_OFS_RAW, 32'h4);
        wr(`HIB_OFS_VIEW, 32'h1);
        rd(`HIB_OFS_RAW, 32'h0);
        wr(`HIB_OFS_VIEW, 32'h0);
        wr(`HIB_OFS_MASK, 32'h4);
        tick(2);
        check(irq, 32'h1);
        wr(`HIB_OFS_CTRL, 32'h0);
        pulse_rtc();
        check(irq, 32'h0);
        rd(`HIB_OFS_RAW, 32'h4);
        wr(`HIB_OFS_CLEAR, 32'hf);
        $display("test done: events");
    endtask : t_events
    // Battery check takes 125 cycles; the store write flags bit 3.
    task automatic t_bat_store();
        bat <= 1'b1;
        wr(`HIB_OFS_CTRL, 32'h1);
        wr(`HIB_OFS_CTRL, 32'h9);
        rd(`HIB_OFS_CTRL, 32'h15);
        tick(140);
        rd(`HIB_OFS_RAW, 32'h2);
        bat <= 1'b0;
        wr(`HIB_OFS_CLEAR, 32'hf);
        wr(8'h7c, 32'hc0de5a5a);
        rd(8'h7c, 32'hc0de5a5a);
        rd(`HIB_OFS_RAW, 32'h8);
        wr(`HIB_OFS_CLEAR, 32'hf);
        $display("test done: battery and store");
    endtask : t_bat_store
    task automatic t_retain();
        gout <= 8'ha5;
        goe <= 8'hff;
        wr(`HIB_OFS_CTRL, 32'h3);
        rd(`HIB_OFS_CTRL, 32'h7);
        hib <= 1'b1;
        tick(3);
        {gout, goe, wake} <= {8'h3c, 8'h00, 1'b1};
        tick(3);
        check({poe, pout}, 16'hffa5);
        {hib, wake} <= 2'h0;
        tick(3);
        check(pout, 8'ha5);
        cpu_rst <= 1'b1;
        tick(2);
        cpu_rst <= 1'b0;
        rd(`HIB_OFS_CTRL, 32'h27);
        rd(`HIB_OFS_RAW, 32'h4);
        wr(`HIB_OFS_CTRL, 32'h1);
        tick(3);
        check(pout, 8'h3c);
        $display("test done: retention");
    endtask : t_retain
    initial begin
        tick(2);
        rst <= 1'b0;
        t_events();
        t_bat_store();
        t_retain();
        give_verdict();
    end
endmodule : tb_hibernate_ctrl_irq
`default_nettype wire
